/* File: include/fga_pkg.sv */
/*
 * constants, register map and encodings for the fib grid allocation control block.
 * assumes a single 200 mhz core clock domain; frame counter and utc time come from
 * logic on that same clock.
 */
// Contract
// - record is hex nibble, one grants fib
// - msb maps to first fib of frame
// - mode iii: four fibs, values zero to fifteen
// - first record aligns to cif low nine zero
// - activation without stored grid reports grid error
// - new grid starts at aligned frame after time
// - active grid holds until next activation time
// - error cause is four chars: nrec, grid; the code also reports cont
// - grid has 500 records, cycles every 500
// - granted fibs go out as stream 5/1
// - grid stored only after error-free session
// - error aborts session, partial grid discarded
package fga_pkg;
	localparam int GRID_RECS = 500;
	localparam int RECS_PER_MSG = 50;
	localparam int MSGS_PER_GRID = 10;
	localparam int IDX_W = 9;
	localparam int CIF_W = 13;
	localparam int CIF_ALIGN_BITS = 9;
	localparam int FIB_W = 4;
	localparam logic [IDX_W-1:0] LAST_IDX = 9'h1f3;
	localparam logic [5:0] MSG_CHARS = 6'h32;
	localparam logic [3:0] MSG_COUNT = 4'ha;
	// register byte offsets
	localparam logic [4:0] OFS_CTRL = 5'h00;
	localparam logic [4:0] OFS_CMD = 5'h04;
	localparam logic [4:0] OFS_CHAR = 5'h08;
	localparam logic [4:0] OFS_ACT_TIME = 5'h0c;
	localparam logic [4:0] OFS_STATUS = 5'h10;
	localparam logic [4:0] OFS_CAUSE = 5'h14;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [23:0] ACT_TIME_RESET = 24'h00_0000;
	// error causes as four ascii characters, no cause as zero
	localparam logic [31:0] CAUSE_NONE = 32'h0000_0000;
	localparam logic [31:0] CAUSE_NREC = 32'h4e52_4543;
	localparam logic [31:0] CAUSE_GRID = 32'h4752_4944;
	localparam logic [31:0] CAUSE_CONT = 32'h434f_4e54;
	// fib stream identifiers
	localparam logic [2:0] FIB_TID = 3'h5;
	localparam logic [2:0] FIB_TIDEXT = 3'h1;
	typedef enum logic [2:0] {
		CMD_NONE = 3'b000,
		CMD_DEF = 3'b001,
		CMD_REC = 3'b010,
		CMD_END = 3'b011,
		CMD_ACT = 3'b100
	} fga_cmd_t;
	typedef enum logic [0:0] {
		SES_IDLE = 1'b0,
		SES_OPEN = 1'b1
	} fga_ses_t;
endpackage

/* File: include/fga_bank_if.sv */
/*
 * interface between the control logic and one grid bank.
 * assumes the owner drives at most one of write and load in a cycle; load wins.
 */
interface fga_bank_if #(parameter int N = fga_pkg::GRID_RECS);
	logic wr_en;
	logic [fga_pkg::IDX_W-1:0] wr_idx;
	logic [fga_pkg::FIB_W-1:0] wr_nib;
	logic load_en;
	logic [N*fga_pkg::FIB_W-1:0] load_data;
	logic [N*fga_pkg::FIB_W-1:0] q;
	modport owner (output wr_en, output wr_idx, output wr_nib, output load_en,
		output load_data, input q);
	modport bank (input wr_en, input wr_idx, input wr_nib, input load_en,
		input load_data, output q);
endinterface

/* File: verilog/fga_grid_bank.sv */
/*
 * one grid bank: N four-bit records in flip-flops, written per record or loaded whole.
 * assumes indices below N; a write past the end is dropped.
 */
module fga_grid_bank #(
	parameter int N = fga_pkg::GRID_RECS
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// bank port
	fga_bank_if.bank bus
);
	import fga_pkg::*;

	logic [N*FIB_W-1:0] q_reg;
	logic [N*FIB_W-1:0] q_next;

	always_comb begin
		q_next = q_reg;
		if (bus.load_en) begin
			q_next = bus.load_data;
		end else if (bus.wr_en && (int'(bus.wr_idx) < N)) begin
			q_next[bus.wr_idx*FIB_W +: FIB_W] = bus.wr_nib;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			q_reg <= '0;
		end else begin
			q_reg <= q_next;
		end
	end

	assign bus.q = q_reg;
endmodule // fga_grid_bank

/* File: verilog/fga_top.sv */
/*
 * fib grid allocation control, receiving end of grid sessions. software feeds the
 * grid messages through avalon-mm registers; the block stages, stores and activates
 * the grid and gates each frame's fib slots for the upstream fib stream.
 * assumes frame_strobe, cif_count and utc_now come from logic on core_clk.
 */
// The implementer's own choices: the register offsets and register access over Avalon-MM.
module fga_top #(
	parameter int N_RECS = fga_pkg::GRID_RECS
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// avalon-mm slave
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// frame timing
	input wire logic frame_strobe,
	input wire logic [fga_pkg::CIF_W-1:0] cif_count,
	input wire logic [23:0] utc_now,
	// fib slot gating
	output logic [fga_pkg::FIB_W-1:0] fib_grant,
	output logic fib_stream_en,
	output logic [2:0] stream_tid,
	output logic [2:0] stream_tidext,
	output logic grid_err
);
	import fga_pkg::*;

	if (N_RECS != RECS_PER_MSG * MSGS_PER_GRID || N_RECS > (1 << IDX_W)) begin : g_bad_n
		$error("N_RECS must equal ten messages of fifty records");
	end

	// ascii hex character to nibble, bit 4 flags a non-hex character
	function automatic logic [4:0] hex_val(input logic [7:0] c);
		if (c >= 8'h30 && c <= 8'h39) begin
			hex_val = {1'b0, 4'(c - 8'h30)};
		end else if (c >= 8'h41 && c <= 8'h46) begin
			hex_val = {1'b0, 4'(c - 8'h37)};
		end else if (c >= 8'h61 && c <= 8'h66) begin
			hex_val = {1'b0, 4'(c - 8'h57)};
		end else begin
			hex_val = 5'h10;
		end
	endfunction

	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		for (int i = 0; i < 4; i++) begin
			be_merge[i*8 +: 8] = be[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction

	fga_bank_if #(.N(N_RECS)) stage_if ();
	fga_bank_if #(.N(N_RECS)) store_if ();
	fga_bank_if #(.N(N_RECS)) active_if ();

	fga_grid_bank #(.N(N_RECS)) u_stage (.core_clk(core_clk), .resetn(resetn),
		.bus(stage_if.bank));
	fga_grid_bank #(.N(N_RECS)) u_store (.core_clk(core_clk), .resetn(resetn),
		.bus(store_if.bank));
	fga_grid_bank #(.N(N_RECS)) u_active (.core_clk(core_clk), .resetn(resetn),
		.bus(active_if.bank));

	// bus slave state
	logic wait_reg;
	logic wait_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	// register and session state
	logic mode3_reg;
	logic mode3_next;
	logic [23:0] act_time_reg;
	logic [23:0] act_time_next;
	fga_ses_t ses_reg;
	fga_ses_t ses_next;
	logic [3:0] msg_cnt_reg;
	logic [3:0] msg_cnt_next;
	logic [5:0] char_cnt_reg;
	logic [5:0] char_cnt_next;
	logic [31:0] cause_reg;
	logic [31:0] cause_next;
	logic stored_reg;
	logic stored_next;
	logic pending_reg;
	logic pending_next;
	logic active_reg;
	logic active_next;
	logic err_reg;
	logic err_next;
	// frame state
	logic [IDX_W-1:0] pos_reg;
	logic [IDX_W-1:0] pos_next;
	logic [FIB_W-1:0] grant_reg;
	logic [FIB_W-1:0] grant_next;
	logic stream_reg;
	logic stream_next;

	logic acc;
	logic wr_acc;
	logic [31:0] rd_mux;
	logic [4:0] hv;
	logic fail;
	logic [31:0] fail_cause;
	logic aligned;
	logic activate;
	fga_cmd_t cmd;
	logic [31:0] ctrl_merged;
	logic [31:0] time_merged;
	// stream identifiers are registered so every output leaves a flip-flop
	logic [2:0] tid_reg;
	logic [2:0] tidext_reg;

	assign acc = (avs_read || avs_write) && !wait_reg;
	assign wr_acc = avs_write && !wait_reg;
	assign cmd = fga_cmd_t'(avs_writedata[2:0]);
	assign hv = hex_val(avs_writedata[7:0]);
	assign aligned = (cif_count[CIF_ALIGN_BITS-1:0] == '0);
	assign ctrl_merged = be_merge({31'h0, mode3_reg}, avs_writedata, avs_byteenable);
	assign time_merged = be_merge({8'h00, act_time_reg}, avs_writedata, avs_byteenable);

	// bus answer: waitrequest drops one cycle after the request rises
	always_comb begin
		unique case (avs_address)
			OFS_CTRL: rd_mux = {31'h0, mode3_reg};
			OFS_ACT_TIME: rd_mux = {8'h00, act_time_reg};
			OFS_STATUS: rd_mux = {18'h0, char_cnt_reg, msg_cnt_reg, active_reg,
				pending_reg, stored_reg, ses_reg};
			OFS_CAUSE: rd_mux = cause_reg;
			default: rd_mux = 32'h0000_0000;
		endcase
		wait_next = 1'b1;
		rdata_next = rdata_reg;
		if ((avs_read || avs_write) && wait_reg) begin
			wait_next = 1'b0;
			rdata_next = avs_read ? rd_mux : 32'h0000_0000;
		end
	end

	// message interpreter
	always_comb begin
		mode3_next = mode3_reg;
		act_time_next = act_time_reg;
		ses_next = ses_reg;
		msg_cnt_next = msg_cnt_reg;
		char_cnt_next = char_cnt_reg;
		cause_next = cause_reg;
		stored_next = stored_reg;
		pending_next = pending_reg;
		fail = 1'b0;
		fail_cause = CAUSE_NONE;
		stage_if.wr_en = 1'b0;
		stage_if.wr_idx = '0;
		stage_if.wr_nib = hv[3:0];
		stage_if.load_en = 1'b0;
		stage_if.load_data = '0;
		store_if.wr_en = 1'b0;
		store_if.wr_idx = '0;
		store_if.wr_nib = '0;
		store_if.load_en = 1'b0;
		store_if.load_data = stage_if.q;
		if (wr_acc && avs_address == OFS_CTRL) begin
			mode3_next = ctrl_merged[0];
		end
		if (wr_acc && avs_address == OFS_ACT_TIME) begin
			act_time_next = time_merged[23:0];
		end
		// characters and records outside an open session are ignored
		if (wr_acc && avs_address == OFS_CHAR && ses_reg == SES_OPEN) begin
			if (hv[4] || (!mode3_reg && hv[0]) || char_cnt_reg == MSG_CHARS) begin
				fail = 1'b1;
				fail_cause = CAUSE_CONT;
			end else begin
				// record n of message m lands at m*50+n, from the aligned frame on
				stage_if.wr_en = (msg_cnt_reg < MSG_COUNT);
				stage_if.wr_idx = IDX_W'(msg_cnt_reg * RECS_PER_MSG) + IDX_W'(char_cnt_reg);
				char_cnt_next = char_cnt_reg + 6'h01;
			end
		end
		if (wr_acc && avs_address == OFS_CMD) begin
			unique case (cmd)
				CMD_DEF: begin
					ses_next = SES_OPEN;
					msg_cnt_next = 4'h0;
					char_cnt_next = 6'h00;
					cause_next = CAUSE_NONE;
				end
				CMD_REC: begin
					if (ses_reg == SES_OPEN) begin
						if (char_cnt_reg != MSG_CHARS) begin
							fail = 1'b1;
							fail_cause = CAUSE_CONT;
						end else begin
							msg_cnt_next = (msg_cnt_reg == 4'hf) ? 4'hf : msg_cnt_reg + 4'h1;
							char_cnt_next = 6'h00;
						end
					end
				end
				CMD_END: begin
					if (ses_reg == SES_OPEN) begin
						if (msg_cnt_reg != MSG_COUNT || char_cnt_reg != 6'h00) begin
							fail = 1'b1;
							fail_cause = CAUSE_NREC;
						end else begin
							store_if.load_en = 1'b1;
							stored_next = 1'b1;
							ses_next = SES_IDLE;
						end
					end
				end
				CMD_ACT: begin
					if (!stored_reg) begin
						fail = 1'b1;
						fail_cause = CAUSE_GRID;
					end else begin
						pending_next = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end
		if (fail) begin
			// aborted session: staged records are simply never promoted
			ses_next = SES_IDLE;
			cause_next = fail_cause;
		end
		if (activate && !(wr_acc && avs_address == OFS_CMD && cmd == CMD_ACT)) begin
			pending_next = 1'b0;
		end
	end

	assign err_next = fail;

	// activation: aligned frame at or after the given time of day
	assign activate = frame_strobe && aligned && pending_reg && (utc_now >= act_time_reg);

	always_comb begin
		active_next = active_reg;
		active_if.wr_en = 1'b0;
		active_if.wr_idx = '0;
		active_if.wr_nib = '0;
		active_if.load_en = activate;
		active_if.load_data = store_if.q;
		if (activate) begin
			active_next = 1'b1;
		end
	end

	// frame position walks the grid cyclically, restarting on every aligned frame
	always_comb begin
		pos_next = pos_reg;
		grant_next = grant_reg;
		stream_next = stream_reg;
		if (frame_strobe) begin
			if (aligned) begin
				pos_next = '0;
			end else if (pos_reg == LAST_IDX) begin
				pos_next = '0;
			end else begin
				pos_next = pos_reg + 9'h001;
			end
			// newly activated grid applies already to this aligned frame
			if (activate) begin
				grant_next = store_if.q[pos_next*FIB_W +: FIB_W];
			end else if (active_reg) begin
				grant_next = active_if.q[pos_next*FIB_W +: FIB_W];
			end else begin
				grant_next = '0;
			end
			// three-fib modes have no fourth slot
			if (!mode3_reg) begin
				grant_next[0] = 1'b0;
			end
			stream_next = (grant_next != '0);
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			wait_reg <= 1'b1;
			rdata_reg <= 32'h0000_0000;
			mode3_reg <= CTRL_RESET[0];
			act_time_reg <= ACT_TIME_RESET;
			ses_reg <= SES_IDLE;
			msg_cnt_reg <= 4'h0;
			char_cnt_reg <= 6'h00;
			cause_reg <= CAUSE_NONE;
			stored_reg <= 1'b0;
			pending_reg <= 1'b0;
			active_reg <= 1'b0;
			err_reg <= 1'b0;
			pos_reg <= '0;
			grant_reg <= '0;
			stream_reg <= 1'b0;
			tid_reg <= FIB_TID;
			tidext_reg <= FIB_TIDEXT;
		end else begin
			wait_reg <= wait_next;
			rdata_reg <= rdata_next;
			mode3_reg <= mode3_next;
			act_time_reg <= act_time_next;
			ses_reg <= ses_next;
			msg_cnt_reg <= msg_cnt_next;
			char_cnt_reg <= char_cnt_next;
			cause_reg <= cause_next;
			stored_reg <= stored_next;
			pending_reg <= pending_next;
			active_reg <= active_next;
			err_reg <= err_next;
			pos_reg <= pos_next;
			grant_reg <= grant_next;
			stream_reg <= stream_next;
			tid_reg <= FIB_TID;
			tidext_reg <= FIB_TIDEXT;
		end
	end

	assign avs_waitrequest = wait_reg;
	assign avs_readdata = rdata_reg;
	assign fib_grant = grant_reg;
	assign fib_stream_en = stream_reg;
	assign stream_tid = tid_reg;
	assign stream_tidext = tidext_reg;
	assign grid_err = err_reg;
endmodule // fga_top

/* File: bench/fga_sva.sv */
/* port assertions for the fib grid block.
 assumes one clock domain, core_clk, and async active-low resetn. */
module fga_sva (
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// register bus
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// frame side
	input wire logic frame_strobe,
	input wire logic [3:0] fib_grant,
	input wire logic fib_stream_en,
	input wire logic [2:0] stream_tid,
	input wire logic [2:0] stream_tidext,
	input wire logic grid_err
);
	timeunit 1ns;
	timeprecision 1ps;
	import fga_pkg::*;
	logic mode_reg;
	logic mode_next;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	// mirror of the mode bit, taken only on an accepted write
	always_comb begin
		mode_next = mode_reg;
		if (avs_write && !avs_waitrequest && avs_address == OFS_CTRL && avs_byteenable[0]) begin
			mode_next = avs_writedata[0];
		end
	end
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			mode_reg <= 1'b0;
		end else begin
			mode_reg <= mode_next;
		end
	end
	sequence s_req;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence s_wr_taken;
		avs_write && !avs_waitrequest;
	endsequence
	a_wait_one: assert property (s_req |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("waitrequest not low for one cycle");
	a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address == 5'h18
		|-> avs_readdata == 32'h0) else $error("unmapped read not zero");
	a_stream_ids: assert property (stream_tid == FIB_TID && stream_tidext == FIB_TIDEXT)
		else $error("stream identifiers wrong");
	a_stream_en: assert property (frame_strobe |=> fib_stream_en == (|fib_grant))
		else $error("stream enable disagrees with grant");
	a_grant_hold: assert property (!frame_strobe |=> $stable(fib_grant))
		else $error("grant moved without a frame");
	a_err_pulse: assert property (grid_err |=> !grid_err)
		else $error("error pulse longer than one cycle");
	a_err_cause: assert property (grid_err |-> $past(avs_write && !avs_waitrequest))
		else $error("error without a write");
	a_even_fib: assert property (!mode_reg && frame_strobe |=> !fib_grant[0])
		else $error("fourth fib granted outside mode three");
	a_read_quiet: assert property (avs_read && !avs_waitrequest |=> !grid_err)
		else $error("read raised an error");
	c_write: cover property (s_wr_taken ##1 grid_err);
endmodule // fga_sva

bind fga_top fga_sva u_sva (.*);

/* File: bench/fga_frame_model.sv */
/* frame timing source standing for the ensemble side: a strobe every
 PERIOD cycles carrying a rising cif count. assumes the bench clock and reset. */
module fga_frame_model #(
	parameter int PERIOD = 4
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// frame timing
	output logic frame_strobe,
	output logic [fga_pkg::CIF_W-1:0] cif_count
);
	timeunit 1ns;
	timeprecision 1ps;
	int cyc;
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			cyc <= 0;
			frame_strobe <= 1'b0;
			cif_count <= '0;
		end else begin
			cyc <= (cyc == PERIOD - 1) ? 0 : cyc + 1;
			frame_strobe <= (cyc == 0);
			// count runs through every low-nine-bit value, so the grid wraps mid-cycle
			if (cyc == 0)
				cif_count <= cif_count + 13'h1;
		end
	end
endmodule // fga_frame_model

/* File: bench/test_fga_top.sv */
/* self-checking bench for the fib grid block.
 assumes the checker is bound in and the frame model drives the frame side. */
module test_fga_top;
	timeunit 1ns;
	timeprecision 1ps;
	import fga_pkg::*;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic [4:0] avs_address = 5'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [3:0] avs_byteenable = 4'hf;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic frame_strobe;
	logic [12:0] cif_count;
	logic [23:0] utc_now = 24'h115959;
	logic [3:0] fib_grant;
	logic fib_stream_en;
	logic [2:0] stream_tid;
	logic [2:0] stream_tidext;
	logic grid_err;
	logic [31:0] rd;
	int err_total = 0;
	int comparisons = 0;
	int cycles = 0;
	always #2.5 core_clk = ~core_clk;
	fga_top u_dut (.*);
	fga_frame_model u_frames (.*);
	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 40000) begin
			err_total++;
			results();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// one bus cycle; an idle edge follows so the next request never shares a time step
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		@(posedge core_clk);
		while (avs_waitrequest !== 1'b0)
			@(posedge core_clk);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge core_clk);
	endtask
	function automatic logic [7:0] hexc(input logic [3:0] v);
		return (v < 4'ha) ? 8'h30 + 8'(v) : 8'h37 + 8'(v);
	endfunction
	task automatic session(input int msgs);
		bus(1'b1, OFS_CMD, 32'h1);
		for (int m = 0; m < msgs; m++) begin
			for (int i = 0; i < 50; i++)
				bus(1'b1, OFS_CHAR, {24'h0, hexc(4'((m * 50 + i) % 16))});
			bus(1'b1, OFS_CMD, 32'h2);
		end
		bus(1'b1, OFS_CMD, 32'h3);
	endtask
	task automatic t_reset();
		check({22'h0, fib_grant, stream_tid, stream_tidext}, 32'h29);
		bus(1'b0, OFS_STATUS, 32'h0);
		check(rd, 32'h0);
		bus(1'b0, 5'h18, 32'h0);
		check(rd, 32'h0);
		bus(1'b1, OFS_CTRL, 32'h1);
		bus(1'b0, OFS_CTRL, 32'h0);
		check(rd, 32'h1);
		$display("t_reset done");
	endtask
	task automatic t_no_grid();
		bus(1'b1, OFS_ACT_TIME, 32'h120000);
		bus(1'b1, OFS_CMD, 32'h4);
		check({31'h0, grid_err}, 32'h1);
		bus(1'b0, OFS_CAUSE, 32'h0);
		check(rd, CAUSE_GRID);
		$display("t_no_grid done");
	endtask
	task automatic t_short();
		session(9);
		check({31'h0, grid_err}, 32'h1);
		bus(1'b0, OFS_CAUSE, 32'h0);
		check(rd, CAUSE_NREC);
		bus(1'b0, OFS_STATUS, 32'h0);
		check(rd & 32'h3, 32'h0);
		$display("t_short done");
	endtask
	task automatic t_content();
		bus(1'b1, OFS_CTRL, 32'h0);
		bus(1'b1, OFS_CMD, 32'h1);
		bus(1'b1, OFS_CHAR, 32'h33);
		check({31'h0, grid_err}, 32'h1);
		bus(1'b0, OFS_CAUSE, 32'h0);
		check(rd, CAUSE_CONT);
		bus(1'b1, OFS_CTRL, 32'h1);
		bus(1'b1, OFS_CMD, 32'h1);
		bus(1'b1, OFS_CHAR, 32'h47);
		check({31'h0, grid_err}, 32'h1);
		// a record character with no open session is dropped silently
		bus(1'b1, OFS_CHAR, 32'h31);
		check({31'h0, grid_err}, 32'h0);
		bus(1'b0, OFS_STATUS, 32'h0);
		check(rd & 32'h3f03, 32'h0);
		$display("t_content done");
	endtask
	task automatic t_grid();
		int idx;
		logic act;
		logic m3;
		logic [3:0] exp4;
		idx = 0;
		act = 1'b0;
		m3 = 1'b1;
		session(10);
		check({31'h0, grid_err}, 32'h0);
		bus(1'b1, OFS_CMD, 32'h4);
		bus(1'b0, OFS_STATUS, 32'h0);
		check(rd & 32'hf, 32'h6);
		// first aligned frame comes before the activation time
		do @(posedge core_clk); while (!(frame_strobe === 1'b1 && cif_count[8:0] == 9'h0));
		@(posedge core_clk);
		check({28'h0, fib_grant}, 32'h0);
		utc_now <= 24'h120000;
		for (int f = 0; f < 1100; f++) begin
			do @(posedge core_clk); while (frame_strobe !== 1'b1);
			if (cif_count[8:0] == 9'h0)
				act = 1'b1;
			idx = (cif_count[8:0] == 9'h0 || idx == 499) ? 0 : idx + 1;
			exp4 = act ? 4'(idx % 16) : 4'h0;
			if (!m3)
				exp4[0] = 1'b0;
			// a mode write launched on the strobe edge lands before the next frame
			if (f == 1000)
				bus(1'b1, OFS_CTRL, 32'h0);
			else
				@(posedge core_clk);
			check({27'h0, fib_stream_en, fib_grant}, {27'h0, exp4 != 4'h0, exp4});
			if (f == 1000)
				m3 = 1'b0;
		end
		bus(1'b0, OFS_STATUS, 32'h0);
		check(rd & 32'hf, 32'ha);
		$display("t_grid done");
	endtask
	initial begin
		repeat (10) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		t_reset();
		t_no_grid();
		t_short();
		t_content();
		t_grid();
		results();
	end
endmodule // test_fga_top
